// [rtl/mmd_decoder.sv]
// Function
// - Register-file accesses as registers take one cycle, other uses two.
// - Reset clears only register A and B locations.
// - Low-power states leave register file and RAM untouched.
// - RAM above first 256 bytes is general memory, two-cycle access.
// - Frame 1 holds system and nonvolatile programming control.
// - Frame 2 holds digital I/O configuration registers.
// - Frames 3-7 internal peripherals; frames 8-11 reserved.
// - Frames 12-15 go external on expansion parts.
// - EEPROM page at top ending 1FFFh, protect byte first.
// - Eight 32-byte blocks per page, protect bit blocks writes.
// - EEPROM reads take two cycles.
// - Program ROM accesses take two cycles.
// - EPROM writes only with programming voltage and select bit.
// - Programming voltage overrides all EEPROM protection in microcomputer mode.
// - Mode pin sampled during reset selects the memory mode on parts with program memory.
// - Twelve volts in single-chip mode gives protect override.
// - Expansion mode: port A data, B/C address, D control.
// - Separate buses; unused port pins stay general I/O.
// - Each port D pin selects chip-select, strobe or I/O.
// - Stack pointer pre-increments on push, post-decrements on pop; resets to 01h.
// - Chip selects fire, each only if enabled, for 2000h-3FFFh and 8000h-FFFFh.
`default_nettype none
module mmd_decoder (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Mode pin level and programming-voltage detect
   input wire logic i_mode_select_pin,
   input wire logic i_prog_voltage,
   // Part options
   input wire logic i_has_expansion,
   input wire logic i_has_prog_mem,
   // CPU access request
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic i_reg_access,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_halt,
   // Stack operations
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic i_load_sp,
   input wire logic [7:0] i_sp_data,
   // Access result
   output logic o_done,
   output logic o_write_ok,
   output logic o_clear_ab,
   output logic [3:0] o_region,
   output logic o_ext_strobe_b,
   output logic [7:0] o_stack_pointer,
   output logic [7:0] o_protect,
   // Mode and port roles
   output logic o_uproc_mode,
   output logic o_protect_override_state,
   output logic o_expansion_active,
   output logic [15:0] o_ext_addr,
   output logic [7:0] o_ext_data,
   output logic o_ext_data_oe,
   output logic [7:0] o_portd_fn_a,
   output logic [7:0] o_portd_fn_b,
   // Chip selects
   output logic o_low_region_select_1,
   output logic o_low_region_select_2,
   output logic o_high_region_select_1,
   output logic o_high_region_select_2,
   output logic o_high_region_select_3
);
   // ------------------------------------------------------------
   // Pin synchroniser (three stages, second and third must agree)
   // ------------------------------------------------------------
   logic [2:0] mc_sync_r;
   logic [2:0] mc_sync_nxt;
   logic [2:0] vpp_sync_r;
   logic [2:0] vpp_sync_nxt;
   logic mc_lvl_r;
   logic mc_lvl_nxt;
   logic vpp_lvl_r;
   logic vpp_lvl_nxt;

   always_comb begin
      mc_sync_nxt = {mc_sync_r[1:0], i_mode_select_pin};
      vpp_sync_nxt = {vpp_sync_r[1:0], i_prog_voltage};
      mc_lvl_nxt = (mc_sync_r[1] == mc_sync_r[2]) ? mc_sync_r[2] : mc_lvl_r;
      vpp_lvl_nxt = (vpp_sync_r[1] == vpp_sync_r[2]) ? vpp_sync_r[2] : vpp_lvl_r;
   end

   // No reset, so the mode pin keeps sampling while reset is held
   always_ff @(posedge i_clk) begin
      mc_sync_r <= mc_sync_nxt;
      vpp_sync_r <= vpp_sync_nxt;
      mc_lvl_r <= mc_lvl_nxt;
      vpp_lvl_r <= vpp_lvl_nxt;
   end

   // ------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------
   function automatic mmd_pkg::mmd_region_t decode_region(input logic [15:0] a,
                                                           input logic uproc,
                                                           input logic expn);
      logic [3:0] fr;
      fr = a[mmd_pkg::PF_FRAME_LSB +: 4];
      if (a <= mmd_pkg::RF_END) begin
         decode_region = mmd_pkg::MMD_REG_FILE;
      end else if (a <= mmd_pkg::RAM_END) begin
         decode_region = mmd_pkg::MMD_RAM;
      end else if (a <= mmd_pkg::PF_END) begin
         if (fr == mmd_pkg::FR_TEST) begin
            decode_region = mmd_pkg::MMD_PF_TEST;
         end else if (fr == mmd_pkg::FR_SYS) begin
            decode_region = mmd_pkg::MMD_PF_SYS;
         end else if (fr == mmd_pkg::FR_DIO) begin
            decode_region = mmd_pkg::MMD_PF_DIO;
         end else if (fr >= mmd_pkg::FR_PERI_LO && fr <= mmd_pkg::FR_PERI_HI) begin
            decode_region = mmd_pkg::MMD_PF_PERI;
         end else if (fr >= mmd_pkg::FR_EXT_LO && expn) begin
            decode_region = mmd_pkg::MMD_PF_EXT;
         end else begin
            decode_region = mmd_pkg::MMD_PF_RSVD;
         end
      end else if (a >= mmd_pkg::EE_BASE && a <= mmd_pkg::EE_END) begin
         decode_region = mmd_pkg::MMD_EEPROM;
      end else if (a >= mmd_pkg::ROM_BASE && a <= mmd_pkg::ROM_END && !uproc) begin
         decode_region = mmd_pkg::MMD_PROG;
      end else if (a >= mmd_pkg::CSL_BASE && expn) begin
         decode_region = mmd_pkg::MMD_EXT;
      end else begin
         decode_region = mmd_pkg::MMD_NONE;
      end
   endfunction

   // ------------------------------------------------------------
   // Mode capture
   // ------------------------------------------------------------
   logic uproc_r;
   logic uproc_nxt;
   logic in_reset_r;
   logic in_reset_nxt;

   always_comb begin
      uproc_nxt = uproc_r;
      in_reset_nxt = !i_rst_b;
      if (!i_rst_b) begin
         // ROM-less parts always come up as microprocessor
         uproc_nxt = mc_lvl_r || !i_has_prog_mem;
      end
   end

   always_ff @(posedge i_clk) begin
      uproc_r <= uproc_nxt;
      in_reset_r <= in_reset_nxt;
   end

   assign o_uproc_mode = uproc_r;
   assign o_clear_ab = in_reset_r && i_rst_b ? 1'b0 : !i_rst_b;
   // Programming voltage only acts in microcomputer mode
   assign o_protect_override_state = vpp_lvl_r && !uproc_r;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic [7:0] eprom_control_reg_r;
   logic [7:0] eprom_control_reg_nxt;
   logic [7:0] fn_a_r;
   logic [7:0] fn_a_nxt;
   logic [7:0] fn_b_r;
   logic [7:0] fn_b_nxt;
   logic [4:0] cs_en_r;
   logic [4:0] cs_en_nxt;
   logic prog_voltage_select_bit;
   logic take;
   logic ee_wr_blocked;
   logic prot_wr;
   mmd_pkg::mmd_region_t region;

   assign take = i_req && !i_halt;
   assign region = decode_region(i_addr, uproc_r, i_has_expansion);
   assign prog_voltage_select_bit = eprom_control_reg_r[mmd_pkg::PROG_VOLTAGE_SELECT_BIT_BIT];

   always_comb begin
      eprom_control_reg_nxt = eprom_control_reg_r;
      fn_a_nxt = fn_a_r;
      fn_b_nxt = fn_b_r;
      cs_en_nxt = cs_en_r;
      if (take && i_wr && !uproc_r) begin
         if (i_addr == mmd_pkg::EPROM_CTL_ADDR) begin
            eprom_control_reg_nxt = i_wdata;
         end
         if (i_addr == mmd_pkg::PORTD_FN_A_ADDR) begin
            fn_a_nxt = i_wdata;
         end
         if (i_addr == mmd_pkg::PORTD_FN_B_ADDR) begin
            fn_b_nxt = i_wdata & ~fn_a_r;
         end
         if (i_addr == mmd_pkg::CS_HIGH_EN_ADDR) begin
            cs_en_nxt = i_wdata[4:0];
         end
      end
      if (uproc_r) begin
         // Microprocessor mode fixes port D to strobe signals
         fn_a_nxt = mmd_pkg::BYTE_ZERO;
         fn_b_nxt = ~mmd_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         eprom_control_reg_r <= mmd_pkg::BYTE_ZERO;
         fn_a_r <= mmd_pkg::BYTE_ZERO;
         fn_b_r <= mmd_pkg::BYTE_ZERO;
         cs_en_r <= '0;
      end else begin
         eprom_control_reg_r <= eprom_control_reg_nxt;
         fn_a_r <= fn_a_nxt;
         fn_b_r <= fn_b_nxt;
         cs_en_r <= cs_en_nxt;
      end
   end

   assign o_portd_fn_a = fn_a_r;
   assign o_portd_fn_b = fn_b_r;

   // ------------------------------------------------------------
   // EEPROM protection
   // ------------------------------------------------------------
   assign prot_wr = take && i_wr && (i_addr == mmd_pkg::EE_PROTECT_ADDR);

   mmd_ee_protect u_protect (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_wr(prot_wr),
      .i_wdata(i_wdata),
      .i_addr(i_addr),
      .i_override(o_protect_override_state),
      .o_protect(o_protect),
      .o_blocked(ee_wr_blocked)
   );

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   typedef enum {MMD_IDLE, MMD_WAIT} mmd_acc_t;
   mmd_acc_t acc_r;
   mmd_acc_t acc_nxt;
   logic write_ok;
   logic fast;

   always_comb begin
      write_ok = 1'b1;
      unique case (region)
         mmd_pkg::MMD_EEPROM: write_ok = !ee_wr_blocked;
         mmd_pkg::MMD_PROG: write_ok = vpp_lvl_r && prog_voltage_select_bit;
         mmd_pkg::MMD_PF_TEST, mmd_pkg::MMD_PF_RSVD, mmd_pkg::MMD_NONE: write_ok = 1'b0;
         default: write_ok = 1'b1;
      endcase
   end

   assign fast = (region == mmd_pkg::MMD_REG_FILE) && i_reg_access;

   always_comb begin
      acc_nxt = acc_r;
      unique case (acc_r)
         MMD_IDLE: begin
            if (take && !fast) begin
               acc_nxt = MMD_WAIT;
            end
         end
         MMD_WAIT: begin
            acc_nxt = MMD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         acc_r <= MMD_IDLE;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   assign o_done = take && (fast || acc_r == MMD_WAIT);
   assign o_write_ok = take && i_wr && write_ok;
   assign o_region = region;

   // ------------------------------------------------------------
   // Expansion bus and chip selects
   // ------------------------------------------------------------
   logic ext_hit;
   logic expn_mode;
   logic [15:0] ext_addr_r;
   logic [15:0] ext_addr_nxt;
   logic [7:0] ext_data_r;
   logic [7:0] ext_data_nxt;

   assign expn_mode = i_has_expansion && (uproc_r || (|fn_a_r) || (|fn_b_r));
   assign ext_hit = take && (region == mmd_pkg::MMD_EXT || region == mmd_pkg::MMD_PF_EXT);
   assign o_expansion_active = expn_mode;

   always_comb begin
      ext_addr_nxt = ext_addr_r;
      ext_data_nxt = ext_data_r;
      if (ext_hit && expn_mode) begin
         ext_addr_nxt = i_addr;
         ext_data_nxt = i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ext_addr_r <= '0;
         ext_data_r <= mmd_pkg::BYTE_ZERO;
      end else begin
         ext_addr_r <= ext_addr_nxt;
         ext_data_r <= ext_data_nxt;
      end
   end

   assign o_ext_addr = ext_addr_r;
   assign o_ext_data = ext_data_r;
   assign o_ext_data_oe = ext_hit && expn_mode && i_wr;
   assign o_ext_strobe_b = !(ext_hit && expn_mode && (|fn_b_r));

   logic low_hit;
   logic high_hit;
   assign low_hit = ext_hit && i_addr >= mmd_pkg::CSL_BASE && i_addr <= mmd_pkg::CSL_END;
   assign high_hit = ext_hit && i_addr >= mmd_pkg::CSH_BASE;

   // Chip selects active low, only when chip-select function set and enabled
   assign o_low_region_select_1 = !(low_hit && fn_a_r[0] && cs_en_r[0]);
   assign o_low_region_select_2 = !(low_hit && fn_a_r[1] && cs_en_r[1]);
   assign o_high_region_select_1 = !(high_hit && fn_a_r[2] && cs_en_r[2]);
   assign o_high_region_select_2 = !(high_hit && fn_a_r[3] && cs_en_r[3]);
   assign o_high_region_select_3 = !(high_hit && fn_a_r[4] && cs_en_r[4]);

   // ------------------------------------------------------------
   // Stack pointer
   // ------------------------------------------------------------
   logic [7:0] sp_r;
   logic [7:0] sp_nxt;

   always_comb begin
      sp_nxt = sp_r;
      if (i_load_sp) begin
         sp_nxt = i_sp_data;
      end else if (i_push) begin
         sp_nxt = sp_r + 8'h01;
      end else if (i_pop) begin
         sp_nxt = sp_r - 8'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sp_r <= mmd_pkg::SP_RESET;
      end else begin
         sp_r <= sp_nxt;
      end
   end

   // Push writes at sp_nxt (already incremented); pop reads at sp_r
   assign o_stack_pointer = sp_r;
endmodule
`default_nettype wire

// [rtl/mmd_ee_protect.sv]
`default_nettype none
module mmd_ee_protect (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Register write
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   // Check
   input wire logic [15:0] i_addr,
   input wire logic i_override,
   // Status
   output logic [7:0] o_protect,
   output logic o_blocked
);
   logic [7:0] prot_r;
   logic [7:0] prot_nxt;

   always_comb begin
      prot_nxt = prot_r;
      if (i_wr && !o_blocked) begin
         prot_nxt = i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         prot_r <= mmd_pkg::BYTE_ZERO;
      end else begin
         prot_r <= prot_nxt;
      end
   end

   // Protect byte covers eight 32-byte blocks; override lifts it
   assign o_protect = prot_r;
   assign o_blocked = prot_r[i_addr[mmd_pkg::EE_BLOCK_LSB +: 3]] && !i_override;
endmodule
`default_nettype wire

// [rtl/mmd_pkg.sv]
`default_nettype none
package mmd_pkg;
   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [15:0] RF_END = 16'h00FF;
   localparam logic [15:0] RAM_END = 16'h0FFF;
   localparam logic [15:0] PF_BASE = 16'h1000;
   localparam logic [15:0] PF_END = 16'h10FF;
   localparam logic [15:0] EE_BASE = 16'h1F00;
   localparam logic [15:0] EE_END = 16'h1FFF;
   localparam logic [15:0] CSL_BASE = 16'h2000;
   localparam logic [15:0] CSL_END = 16'h3FFF;
   localparam logic [15:0] CSH_BASE = 16'h8000;
   localparam logic [15:0] ROM_BASE = 16'h7000;
   localparam logic [15:0] ROM_END = 16'h7FFF;
   localparam logic [15:0] ROM_RSV_LO = 16'h7FE0;
   localparam logic [15:0] ROM_RSV_HI = 16'h7FEB;
   localparam logic [15:0] REG_A_ADDR = 16'h0000;
   localparam logic [15:0] REG_B_ADDR = 16'h0001;
   localparam logic [15:0] EE_PROTECT_ADDR = 16'h1F00;
   localparam logic [15:0] EPROM_CTL_ADDR = 16'h101C;
   localparam logic [15:0] PORTD_FN_A_ADDR = 16'h102C;
   localparam logic [15:0] PORTD_FN_B_ADDR = 16'h102D;
   localparam logic [15:0] CS_HIGH_EN_ADDR = 16'h102E;

   // ------------------------------------------------------------
   // Fields and values
   // ------------------------------------------------------------
   localparam int PF_FRAME_LSB = 4;
   localparam int EE_BLOCK_LSB = 5;
   localparam int PROG_VOLTAGE_SELECT_BIT_BIT = 6;
   localparam logic [3:0] FR_TEST = 4'h0;
   localparam logic [3:0] FR_SYS = 4'h1;
   localparam logic [3:0] FR_DIO = 4'h2;
   localparam logic [3:0] FR_PERI_LO = 4'h3;
   localparam logic [3:0] FR_PERI_HI = 4'h7;
   localparam logic [3:0] FR_EXT_LO = 4'hC;
   localparam logic [7:0] SP_RESET = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] LAT_FAST = 2'h1;
   localparam logic [1:0] LAT_SLOW = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MMD_REG_FILE, MMD_RAM, MMD_PF_TEST, MMD_PF_SYS, MMD_PF_DIO, MMD_PF_PERI,
      MMD_PF_RSVD, MMD_PF_EXT, MMD_EEPROM, MMD_PROG, MMD_EXT, MMD_NONE
   } mmd_region_t;
endpackage
`default_nettype wire

// [testbench/mmd_decoder_monitor.sv]
`default_nettype none
module mmd_decoder_monitor (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Inputs
   input wire logic i_prog_voltage,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic i_reg_access,
   input wire logic [15:0] i_addr,
   input wire logic i_halt,
   input wire logic i_push,
   input wire logic i_load_sp,
   // Outputs
   input wire logic o_done,
   input wire logic o_write_ok,
   input wire logic o_clear_ab,
   input wire logic [3:0] o_region,
   input wire logic [7:0] o_stack_pointer,
   input wire logic o_uproc_mode,
   input wire logic o_protect_override_state
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Helpers
   // ----
   logic fast;
   logic fresh_r;
   assign fast = i_req && !i_halt && i_reg_access && (i_addr <= 16'h00FF);
   // A held request is only new again after a completion
   always_ff @(posedge i_clk) begin
      fresh_r <= !i_rst_b || o_done || !i_req;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_fast_reg_done: assert property (fast |-> o_done)
      else $error("register access not done in one cycle");
   a_slow_two_cycles: assert property (i_req && !i_halt && !fast && fresh_r
      |-> !o_done ##1 o_done)
      else $error("slow access not done in two cycles");
   a_reset_clears_ab: assert property ($rose(i_rst_b) |-> $past(o_clear_ab)
      && !o_clear_ab && o_stack_pointer == mmd_pkg::SP_RESET)
      else $error("reset clear or stack reset wrong");
   a_push_pre_inc: assert property (i_push && !i_load_sp
      |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
      else $error("push did not increment stack pointer");
   a_override_on: assert property (i_prog_voltage [*6] ##0 !o_uproc_mode
      |-> o_protect_override_state)
      else $error("override missing under programming voltage");
   a_override_off: assert property ((!i_prog_voltage) [*6]
      |-> !o_protect_override_state)
      else $error("override without programming voltage");
   a_frame_sys: assert property (i_req && i_addr[15:4] == 12'h101
      |-> o_region == mmd_pkg::MMD_PF_SYS)
      else $error("frame 1 decoded wrong");
   a_ram_region: assert property (i_req && i_addr inside {[16'h0100:16'h0FFF]}
      |-> o_region == mmd_pkg::MMD_RAM)
      else $error("general RAM decoded wrong");
   a_ee_override_write: assert property (i_req && !i_halt && i_wr
      && o_protect_override_state && i_addr inside {[16'h1F01:16'h1FFF]} |-> o_write_ok)
      else $error("override did not open EEPROM");
   a_eprom_blocked: assert property (i_req && i_wr && !o_uproc_mode
      && !o_protect_override_state && i_addr inside {[16'h7000:16'h7FFF]}
      |-> !o_write_ok)
      else $error("EPROM write allowed without voltage");
endmodule
`default_nettype wire

// [testbench/mmd_ext_mem.sv]
`default_nettype none
module mmd_ext_mem (
   // Clock
   input wire logic i_clk,
   // Expansion bus from the device
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic oe_q;
   // Store once the write ends; the latched address and data stand by then
   always @(posedge i_clk) begin
      oe_q <= i_data_oe;
      if (oe_q && !i_data_oe) begin
         mem[i_addr[7:0]] <= i_data;
      end
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, mpin, pv, hexp, hprog, req, wr, rga, halt, push, pop, ldsp;
   logic [15:0] addr, ext_addr;
   logic [7:0] wdata, spd, sp, prot, ext_data, fna, fnb;
   logic done, write_ok, clear_ab, uproc, ovr, ext_oe, expn, stb_b, wok, stb_seen_b;
   logic csl1, csl2, high_region_select_1, high_region_select_2, high_region_select_3;
   logic [4:0] cs_b;
   logic [3:0] region, rgn;
   int lat, bad_count, total_checks, cyc;

   mmd_decoder u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_mode_select_pin(mpin),
      .i_prog_voltage(pv), .i_has_expansion(hexp), .i_has_prog_mem(hprog),
      .i_req(req), .i_wr(wr), .i_reg_access(rga), .i_addr(addr), .i_wdata(wdata),
      .i_halt(halt), .i_push(push), .i_pop(pop), .i_load_sp(ldsp), .i_sp_data(spd),
      .o_done(done), .o_write_ok(write_ok), .o_clear_ab(clear_ab), .o_region(region),
      .o_ext_strobe_b(stb_b), .o_stack_pointer(sp), .o_protect(prot), .o_uproc_mode(uproc),
      .o_protect_override_state(ovr), .o_expansion_active(expn), .o_ext_addr(ext_addr),
      .o_ext_data(ext_data), .o_ext_data_oe(ext_oe), .o_portd_fn_a(fna),
      .o_portd_fn_b(fnb),
      .o_low_region_select_1(csl1), .o_low_region_select_2(csl2),
      .o_high_region_select_1(high_region_select_1), .o_high_region_select_2(high_region_select_2),
      .o_high_region_select_3(high_region_select_3));
   mmd_ext_mem u_ext (.i_clk(clk), .i_addr(ext_addr), .i_data(ext_data),
      .i_data_oe(ext_oe));

   always #25 clk = ~clk;
   // ----
   // Tasks
   // ----
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request stands through the completion edge and drops at the next falling edge
   task automatic acc(input logic w, input logic r, input logic [15:0] a,
      input logic [7:0] d);
      @(negedge clk);
      req = 1'b1;
      wr = w;
      rga = r;
      addr = a;
      wdata = d;
      lat = 1;
      // Let the combinational answer settle before the first look
      #1;
      while (done !== 1'b1 && lat < 9) begin
         @(negedge clk);
         lat++;
      end
      wok = write_ok;
      rgn = region;
      cs_b = {csl1, csl2, high_region_select_1, high_region_select_2, high_region_select_3};
      stb_seen_b = stb_b;
      @(negedge clk);
      req = 1'b0;
   endtask
   task automatic rd(input logic r, input logic [15:0] a, input logic [3:0] g, input int l);
      acc(1'b0, r, a, 8'h00);
      chk(16'(rgn), 16'(g));
      chk(16'(lat), 16'(l));
   endtask
   task automatic wchk(input logic [15:0] a, input logic [7:0] d, input logic e);
      acc(1'b1, 1'b0, a, d);
      chk(16'(wok), 16'(e));
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         give_verdict();
      end
   end
   // ----
   // Sequence
   // ----
   initial begin
      clk = 0;
      rst_b = 0;
      mpin = 0;
      pv = 0;
      hexp = 1;
      hprog = 1;
      req = 0;
      wr = 0;
      rga = 0;
      addr = 16'h0000;
      wdata = 8'h00;
      halt = 0;
      push = 0;
      pop = 0;
      ldsp = 0;
      spd = 8'h00;
      bad_count = 0;
      total_checks = 0;
      cyc = 0;
      repeat (8) @(negedge clk);
      chk(16'(clear_ab), 16'h0001);
      rst_b = 1;
      @(negedge clk);
      chk(16'(clear_ab), 16'h0000);
      chk(16'(sp), 16'h0001);
      chk(16'(prot), 16'h0000);
      chk(16'(uproc), 16'h0000);
      chk(16'(expn), 16'h0000);
      rd(1'b1, 16'h0005, mmd_pkg::MMD_REG_FILE, 1);
      rd(1'b0, 16'h00FF, mmd_pkg::MMD_REG_FILE, 2);
      rd(1'b0, 16'h0100, mmd_pkg::MMD_RAM, 2);
      rd(1'b0, 16'h1010, mmd_pkg::MMD_PF_SYS, 2);
      rd(1'b0, 16'h102F, mmd_pkg::MMD_PF_DIO, 2);
      rd(1'b0, 16'h107F, mmd_pkg::MMD_PF_PERI, 2);
      rd(1'b0, 16'h1080, mmd_pkg::MMD_PF_RSVD, 2);
      rd(1'b0, 16'h10C0, mmd_pkg::MMD_PF_EXT, 2);
      rd(1'b0, 16'h1F40, mmd_pkg::MMD_EEPROM, 2);
      rd(1'b0, 16'h7000, mmd_pkg::MMD_PROG, 2);
      rd(1'b0, 16'h2000, mmd_pkg::MMD_EXT, 2);
      // A part without expansion keeps the top frames reserved and nothing outside
      hexp = 0;
      rd(1'b0, 16'h10C0, mmd_pkg::MMD_PF_RSVD, 2);
      rd(1'b0, 16'h2000, mmd_pkg::MMD_NONE, 2);
      hexp = 1;
      // Test frame and reserved ROM words are never touched
      // Port D needs a bus function before any external cycle runs
      wchk(16'h102C, 8'hFF, 1'b1);
      chk(16'(fna), 16'h00FF);
      chk(16'(expn), 16'h0001);
      wchk(16'h102D, 8'h0F, 1'b1);
      chk(16'(fnb), 16'h0000);
      wchk(16'h102E, 8'h1F, 1'b1);
      acc(1'b1, 1'b0, 16'h10C5, 8'hA5);
      chk(16'(stb_seen_b), 16'h0001);
      chk(ext_addr, 16'h10C5);
      chk(16'(ext_data), 16'h00A5);
      repeat (2) @(negedge clk);
      chk(16'(u_ext.mem[8'hC5]), 16'h00A5);
      wchk(16'h1F00, 8'h02, 1'b1);
      chk(16'(prot), 16'h0002);
      wchk(16'h1F20, 8'h55, 1'b0);
      wchk(16'h1F3F, 8'h55, 1'b0);
      wchk(16'h1F40, 8'h55, 1'b1);
      wchk(16'h7000, 8'h11, 1'b0);
      wchk(16'h101C, 8'h40, 1'b1);
      wchk(16'h7000, 8'h11, 1'b0);
      pv = 1;
      repeat (8) @(negedge clk);
      chk(16'(ovr), 16'h0001);
      wchk(16'h1F20, 8'h66, 1'b1);
      wchk(16'h7000, 8'h11, 1'b1);
      wchk(16'h101C, 8'h00, 1'b1);
      wchk(16'h7000, 8'h11, 1'b0);
      pv = 0;
      repeat (8) @(negedge clk);
      chk(16'(ovr), 16'h0000);
      push = 1;
      @(negedge clk);
      push = 0;
      chk(16'(sp), 16'h0002);
      pop = 1;
      @(negedge clk);
      pop = 0;
      chk(16'(sp), 16'h0001);
      spd = 8'hFF;
      ldsp = 1;
      @(negedge clk);
      ldsp = 0;
      push = 1;
      @(negedge clk);
      push = 0;
      chk(16'(sp), 16'h0000);
      halt = 1;
      req = 1;
      wr = 1;
      addr = 16'h1F00;
      wdata = 8'h00;
      repeat (3) @(negedge clk);
      chk(16'(done), 16'h0000);
      chk(16'(prot), 16'h0002);
      req = 0;
      halt = 0;
      // Selects ordered low 1, low 2, high 1, high 2, high 3; all active low
      acc(1'b0, 1'b0, 16'h3FFF, 8'h00);
      chk(16'(cs_b), 16'h0007);
      acc(1'b0, 1'b0, 16'h8000, 8'h00);
      chk(16'(cs_b), 16'h0018);
      acc(1'b0, 1'b0, 16'h1F40, 8'h00);
      chk(16'(cs_b), 16'h001F);
      mpin = 1;
      rst_b = 0;
      repeat (8) @(negedge clk);
      rst_b = 1;
      @(negedge clk);
      chk(16'(uproc), 16'h0001);
      chk(16'(sp), 16'h0001);
      chk(16'(fnb), 16'h00FF);
      acc(1'b0, 1'b0, 16'h7000, 8'h00);
      chk(16'(rgn), 16'(mmd_pkg::MMD_EXT));
      chk(16'(stb_seen_b), 16'h0000);
      mpin = 0;
      hprog = 0;
      rst_b = 0;
      repeat (8) @(negedge clk);
      rst_b = 1;
      @(negedge clk);
      chk(16'(uproc), 16'h0001);
      give_verdict();
   end
endmodule

bind mmd_decoder mmd_decoder_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_prog_voltage(i_prog_voltage), .i_req(i_req), .i_wr(i_wr),
   .i_reg_access(i_reg_access), .i_addr(i_addr), .i_halt(i_halt), .i_push(i_push),
   .i_load_sp(i_load_sp), .o_done(o_done), .o_write_ok(o_write_ok),
   .o_clear_ab(o_clear_ab), .o_region(o_region), .o_stack_pointer(o_stack_pointer),
   .o_uproc_mode(o_uproc_mode), .o_protect_override_state(o_protect_override_state));
`default_nettype wire
